//--- verification/osdsb_flyback_gen.sv
// osdsb_flyback_gen: deflection model driving both flyback levels.
// assumes: bench pixel clock; levels change on the falling edge.
`timescale 1ns/1ps
module osdsb_flyback_gen
#(
    parameter int LINE_PIX = 64,
    parameter int FRAME_LN = 140
)
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // flyback levels
    output logic      hflyback_o,
    output logic      vflyback_o
);
    int t;
    // short line keeps runs brief; scan-rate advice per code is not modelled
    // both flybacks always supplied, frame within 1536 lines
    always @(negedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            t = 0;
        else
            t = (t + 1) % (LINE_PIX * FRAME_LN);
        hflyback_o <= !rst_i && (t % LINE_PIX) < 8;
        // vertical starts mid-line, never on a horizontal edge
        vflyback_o <= !rst_i && t >= 20 && t < 20 + 2 * LINE_PIX;
    end
endmodule

//--- verification/osdsb_top_sva.sv
// osdsb_top_sva: port-level timing checks for the sync and blanking block.
// assumes: bound to osdsb_top, sees its ports only.
`timescale 1ns/1ps
module osdsb_top_sva
    import osdsb_pkg::*;
#(
    parameter int PIX_W = OSDSB_PIX_W
)
(
    // clock and reset
    input wire logic             clk_i,
    input wire logic             rst_i,
    // inputs
    input wire logic             hflyback_i,
    input wire logic             vflyback_i,
    input wire logic [15:0]      reg_addr_i,
    input wire logic             reg_wr_i,
    input wire logic [7:0]       reg_wdata_i,
    // outputs
    input wire logic             osd_sync_o,
    input wire logic             hblank_o,
    input wire logic             vblank_o,
    input wire logic             blank_o,
    input wire logic [PIX_W-1:0] pix_per_line_o,
    input wire logic             pll_auto_o
);
    logic             h_q, v_q, hb_q, vb_q, lw_q, lw2_q, aw_q, aw2_q;
    logic [6:0]       n_q;
    logic [7:0]       cnt_q;
    logic [PIX_W-1:0] ppl_q;
    wire logic        h_rise = hflyback_i & ~h_q;
    wire logic        v_rise = vflyback_i & ~v_q;
    wire logic        any_bl = hblank_o | vblank_o;
    wire logic        wr_hb  = reg_wr_i && reg_addr_i == OSDSB_REG_HBLANK;
    wire logic        wr_vb  = reg_wr_i && reg_addr_i == OSDSB_REG_VBLANK;
    wire logic        wr_ll  = reg_wr_i && reg_addr_i == OSDSB_REG_LINE_LEN;
    wire logic        wr_au  = reg_wr_i && reg_addr_i == OSDSB_REG_RANGE_CTL && reg_wdata_i[6];
    wire logic [7:0]  n_min  = (n_q < 7'h03) ? 8'h03 : {1'b0, n_q};
    // shadow of the register fields and a line counter since vertical start
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {h_q, v_q, lw_q, lw2_q, aw_q, aw2_q} <= '0;
            hb_q  <= OSDSB_HBLANK_RST[0];
            vb_q  <= OSDSB_VBLANK_RST[7];
            n_q   <= OSDSB_VBLANK_RST[6:0];
            cnt_q <= 8'h00;
            ppl_q <= '0;
        end
        else
        begin
            {h_q, v_q} <= {hflyback_i, vflyback_i};
            {lw_q, lw2_q, aw_q, aw2_q} <= {wr_ll, lw_q, wr_au, aw_q};
            if (wr_hb)
                hb_q <= reg_wdata_i[0];
            if (wr_vb)
                {vb_q, n_q} <= reg_wdata_i;
            if (wr_ll)
                ppl_q <= PIX_W'(704 + 64 * reg_wdata_i[7:5]);
            if (v_rise)
                cnt_q <= 8'h00;
            else if (h_rise && cnt_q != 8'hFF)
                cnt_q <= cnt_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_hstart;
        hb_q && h_rise;
    endsequence
    sequence s_vstart;
        vb_q && v_rise;
    endsequence
    blank_follow_a: assert property (blank_o == $past(any_bl))
        else $error("blank not one cycle behind");
    ppl_write_a: assert property (lw2_q |-> pix_per_line_o == ppl_q)
        else $error("line length wrong");
    sync_edge_a: assert property ($rose(osd_sync_o) |->
        $past(h_rise, 2) || $past(v_rise, 2))
        else $error("sync without flyback edge");
    hb_rise_a: assert property (s_hstart |=> hblank_o)
        else $error("hblank late");
    hb_off_a: assert property (!hb_q && !$past(hb_q) |-> !hblank_o)
        else $error("hblank while disabled");
    vb_rise_a: assert property (s_vstart |=> vblank_o)
        else $error("vblank late");
    vb_off_a: assert property (!vb_q && !$past(vb_q) |-> !vblank_o)
        else $error("vblank while disabled");
    vb_len_a: assert property (vblank_o |-> cnt_q < n_min)
        else $error("vblank too long");
    auto_rise_a: assert property ($rose(pll_auto_o) |-> $past(aw2_q))
        else $error("auto without write");
endmodule
bind osdsb_top osdsb_top_sva #(.PIX_W(PIX_W)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
    .hflyback_i(hflyback_i), .vflyback_i(vflyback_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .osd_sync_o(osd_sync_o),
    .hblank_o(hblank_o), .vblank_o(vblank_o), .blank_o(blank_o),
    .pix_per_line_o(pix_per_line_o), .pll_auto_o(pll_auto_o));

//--- verification/osdsb_top_tb.sv
// osdsb_top_tb: self-checking bench for the sync and blanking block.
// assumes: package, design, checker and flyback model compiled first.
`timescale 1ns/1ps
module osdsb_top_tb import osdsb_pkg::*;;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        hfb, vfb, sync, hbl, vbl, bl, ls, auto, seen;
    logic [7:0]  rdata;
    logic [10:0] pixels_per_line_code;
    logic [1:0]  rng;
    int          bad_count = 0;
    int          checked = 0;
    int          seed = 32'h5452;
    int          exp_q[$];
    int          n, k, t;
    always #12.5 clk = ~clk; // 40 MHz pixel clock, under the pixel limit
    osdsb_top i_dut (.clk_i(clk), .rst_i(rst), .hflyback_i(hfb), .vflyback_i(vfb),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .osd_sync_o(sync), .hblank_o(hbl), .vblank_o(vbl), .blank_o(bl),
        .line_start_o(ls), .pix_per_line_o(pixels_per_line_code), .pll_range_o(rng), .pll_auto_o(auto));
    osdsb_flyback_gen i_fb (.clk_i(clk), .rst_i(rst), .hflyback_o(hfb), .vflyback_o(vfb));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
        addr = a;
        repeat (2) @(negedge clk);
        chk(16'(rdata & m), 16'(e & m));
    endtask
    function automatic logic sig(input int w);
        return w == 0 ? vbl : w == 1 ? vfb : w == 2 ? hbl : hfb;
    endfunction
    task automatic wait_lvl(input int w, input logic lvl);
        int i;
        i = 0;
        while (sig(w) !== lvl && i < 20000)
        begin
            @(negedge clk);
            i++;
        end
        chk(16'(sig(w) === lvl), 16'h1);
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd_chk(OSDSB_REG_LINE_LEN, OSDSB_LINE_LEN_RST, 8'hFF);
        rd_chk(OSDSB_REG_HBLANK, OSDSB_HBLANK_RST, 8'hFF);
        rd_chk(OSDSB_REG_VBLANK, OSDSB_VBLANK_RST, 8'hFF);
        rd_chk(OSDSB_REG_RANGE_CTL, OSDSB_RANGE_CTL_RST, 8'h7C);
        rd_chk(16'h8400, 8'h00, 8'hFF);
        for (k = 0; k < 8; k++)
        begin
            t = {$random(seed)} % 32;
            wr_reg(OSDSB_REG_LINE_LEN, {k[2:0], t[4:0]});
            repeat (2) @(negedge clk);
            chk(16'(pixels_per_line_code), 16'(704 + 64 * k));
            rd_chk(OSDSB_REG_LINE_LEN, {k[2:0], t[4:0]}, 8'hFF);
        end
        // short, minimum, and a random length of ten or more
        exp_q = {2, 3, 10 + {$random(seed)} % 118};
        while (exp_q.size() > 0)
        begin
            n = exp_q.pop_front();
            wr_reg(OSDSB_REG_VBLANK, {1'b1, n[6:0]});
            wait_lvl(0, 1'b1);
            k = 0;
            t = hfb;
            while (vbl === 1'b1)
            begin
                @(negedge clk);
                if (hfb && t == 0)
                    k++;
                t = hfb;
            end
            chk(16'(k), 16'(n < 3 ? 3 : n));
        end
        wr_reg(OSDSB_REG_VBLANK, 8'h0A);
        wr_reg(OSDSB_REG_HBLANK, 8'h00);
        wait_lvl(1, 1'b1);
        seen = 1'b0;
        repeat (300)
        begin
            @(negedge clk);
            seen = seen | vbl | hbl;
        end
        chk(16'(seen), 16'h0);
        wr_reg(OSDSB_REG_HBLANK, 8'h25);
        wait_lvl(3, 1'b0);
        wait_lvl(2, 1'b0);
        wait_lvl(2, 1'b1);
        k = 0;
        while (hfb !== 1'b1 && k < 100)
        begin
            @(negedge clk);
            k++;
        end
        // four steps of lead; the bench sees the flyback one clock late
        chk(16'(k), 16'(OSDSB_HB_STEP_PIX * 4 + 1));
        chk(16'(ls), 16'h1);
        @(negedge clk);
        chk(16'(ls), 16'h0);
        wr_reg(OSDSB_REG_HBLANK, 8'h01);
        wait_lvl(1, 1'b0);
        wr_reg(OSDSB_REG_RANGE_CTL, 8'h00);
        rd_chk(OSDSB_REG_RANGE_CTL, 8'h00, 8'h80);
        wait_lvl(1, 1'b1);
        rd_chk(OSDSB_REG_RANGE_CTL, 8'h80, 8'h80);
        wait_lvl(1, 1'b0);
        wait_lvl(1, 1'b1);
        wr_reg(OSDSB_REG_RANGE_CTL, 8'h40);
        repeat (2) @(negedge clk);
        chk(16'(auto), 16'h1);
        wait_lvl(1, 1'b0);
        wait_lvl(1, 1'b1);
        chk(16'(rng), 16'(OSDSB_RANGE_TOP));
        wr_reg(OSDSB_REG_RANGE_CTL, 8'h00);
        repeat (2) @(negedge clk);
        chk(16'(auto), 16'h0);
        chk(16'(sync), 16'h1);
        wrap_up();
    end
    initial
    begin
        #(25 * 95000);
        bad_count++;
        wrap_up();
    end
endmodule

//--- verilog/osdsb_pkg.sv
// osdsb_pkg: register map, field layout and timing constants for the
// sync, blanking and pixel-pll control block.
// assumes: included before the block's modules are compiled.
package osdsb_pkg;
    // register offsets
    localparam logic [15:0] OSDSB_REG_LINE_LEN   = 16'h8401;
    localparam logic [15:0] OSDSB_REG_HBLANK     = 16'h843A;
    localparam logic [15:0] OSDSB_REG_VBLANK     = 16'h843B;
    localparam logic [15:0] OSDSB_REG_RANGE_CTL  = 16'h843E;
    // field positions
    localparam int          OSDSB_PPL_LSB        = 5;
    localparam int          OSDSB_PPL_MSB        = 7;
    localparam int          OSDSB_HB_EN_BIT      = 0;
    localparam int          OSDSB_VB_EN_BIT      = 7;
    localparam int          OSDSB_HB_PROG_BIT    = 2;
    localparam int          OSDSB_HB_STEP_LSB    = 3;
    localparam int          OSDSB_HB_STEP_MSB    = 6;
    localparam int          OSDSB_RANGE_LSB      = 0;
    localparam int          OSDSB_RANGE_MSB      = 1;
    localparam int          OSDSB_AUTO_BIT       = 6;
    localparam int          OSDSB_CAL_DONE_BIT   = 7;
    // reset values
    localparam logic [7:0]  OSDSB_LINE_LEN_RST   = 8'h00;
    localparam logic [7:0]  OSDSB_HBLANK_RST     = 8'h01;
    localparam logic [7:0]  OSDSB_VBLANK_RST     = 8'h0A;
    localparam logic [7:0]  OSDSB_RANGE_CTL_RST  = 8'h00;
    // line and blanking figures
    localparam int          OSDSB_PPL_BASE       = 704;
    localparam int          OSDSB_PPL_STEP       = 64;
    localparam int          OSDSB_HB_STEP_PIX    = 4;
    localparam logic [6:0]  OSDSB_VB_MIN_LINES   = 7'h03;
    localparam logic [6:0]  OSDSB_VB_MAX_LINES   = 7'h7F;
    localparam int          OSDSB_PIX_W          = 11;
    localparam int          OSDSB_RANGES         = 4;
    localparam logic [1:0]  OSDSB_RANGE_TOP      = 2'h3;
    // range finder states
    typedef enum logic [2:0] {
        OSDSB_RF_IDLE,
        OSDSB_RF_CAL,
        OSDSB_RF_READY,
        OSDSB_RF_AUTO
    } osdsb_rf_t;
endpackage

//--- verilog/osdsb_range_sel.sv
// osdsb_range_sel: automatic pll range choice from measured line length.
// assumes: line_cnt_i is the pixel count of the last full line, valid on line_end_i.
`timescale 1ns/1ps
module osdsb_range_sel
    import osdsb_pkg::*;
#(
    parameter int PIX_W = OSDSB_PIX_W
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // measurement
    input  wire logic             line_end_i,
    input  wire logic [PIX_W-1:0] line_cnt_i,
    input  wire logic [PIX_W-1:0] target_i,
    input  wire logic             enable_i,
    // chosen range
    output logic [1:0]            range_o
);
    // step range toward the one whose count matches the programmed line length
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            range_o <= 2'h0;
        else if (enable_i && line_end_i)
        begin
            if (line_cnt_i < target_i && range_o != OSDSB_RANGE_TOP)
                range_o <= range_o + 2'h1;
            else if (line_cnt_i > target_i && range_o != 2'h0)
                range_o <= range_o - 2'h1;
        end
    end
endmodule

//--- verilog/osdsb_top.sv
// osdsb_top: flyback sync, horizontal and vertical blanking, pll line-length
// and range control with automatic range calibration.
// assumes: clk_i is the line-locked pixel clock, flybacks are synchronous
// active-high levels, registers written through the parallel port below.
// How it works
// - osd sync is reported only while both flybacks have been seen
// - vertical flyback blanks outputs for the programmed 3 to 127 lines
// - horizontal blank starts 0 to 60 pixels before horizontal flyback
// - each blanking type has its own disable bit
// - line lengths 704 to 1152 pixels in steps of 64
// - line-length code sits in bits 7:5 of the line-length register
// - auto mode picks the pll range itself, entered only from a completed calibration
// - pre-calibration completes within one vertical period
// - lead is four-bit step count of four pixels, needs both enables
`timescale 1ns/1ps
module osdsb_top
    import osdsb_pkg::*;
#(
    parameter int PIX_W = OSDSB_PIX_W
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // flyback inputs
    input  wire logic        hflyback_i,
    input  wire logic        vflyback_i,
    // register port
    input  wire logic [15:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic [7:0]       reg_rdata_o,
    // timing outputs
    output logic             osd_sync_o,
    output logic             hblank_o,
    output logic             vblank_o,
    output logic             blank_o,
    output logic             line_start_o,
    // pll control
    output logic [PIX_W-1:0] pix_per_line_o,
    output logic [1:0]       pll_range_o,
    output logic             pll_auto_o
);
    logic [7:0]       line_len_q;
    logic [7:0]       hblank_q;
    logic [7:0]       vblank_q;
    logic [7:0]       range_ctl_q;
    logic             hfb_d1_q;
    logic             vfb_d1_q;
    logic             h_seen_q;
    logic             v_seen_q;
    logic [PIX_W-1:0] pix_cnt_q;
    logic [PIX_W-1:0] line_meas_q;
    logic [PIX_W-1:0] lead_pix;
    logic [PIX_W-1:0] target_pix;
    logic [6:0]       vb_cnt_q;
    logic [6:0]       vb_lines;
    logic             lead_on;
    logic             h_rise;
    logic             v_rise;
    logic             cal_done_q;
    logic             cal_start;
    logic [1:0]       auto_range;
    osdsb_rf_t        rf_q;

    // line length in pixels for a three-bit code
    function automatic logic [PIX_W-1:0] ppl_pixels(input logic [2:0] code);
        ppl_pixels = PIX_W'(OSDSB_PPL_BASE + OSDSB_PPL_STEP * int'(code));
    endfunction

    assign h_rise     = hflyback_i && !hfb_d1_q;
    assign v_rise     = vflyback_i && !vfb_d1_q;
    assign target_pix = ppl_pixels(line_len_q[OSDSB_PPL_MSB:OSDSB_PPL_LSB]);
    assign lead_pix   = PIX_W'(OSDSB_HB_STEP_PIX
                        * int'(hblank_q[OSDSB_HB_STEP_MSB:OSDSB_HB_STEP_LSB]));
    assign lead_on    = hblank_q[OSDSB_HB_EN_BIT] && hblank_q[OSDSB_HB_PROG_BIT];
    // clamp programmed vertical lines to legal span
    assign vb_lines   = (vblank_q[OSDSB_VB_EN_BIT-1:0] < OSDSB_VB_MIN_LINES)
                        ? OSDSB_VB_MIN_LINES : vblank_q[OSDSB_VB_EN_BIT-1:0];
    assign cal_start  = reg_wr_i && reg_addr_i == OSDSB_REG_RANGE_CTL && !reg_wdata_i[OSDSB_AUTO_BIT]
                        && reg_wdata_i[OSDSB_RANGE_MSB:OSDSB_RANGE_LSB] == 2'h0;

    // register writes
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            line_len_q  <= OSDSB_LINE_LEN_RST;
            hblank_q    <= OSDSB_HBLANK_RST;
            vblank_q    <= OSDSB_VBLANK_RST;
            range_ctl_q <= OSDSB_RANGE_CTL_RST;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                OSDSB_REG_LINE_LEN:  line_len_q  <= reg_wdata_i;
                OSDSB_REG_HBLANK:    hblank_q    <= reg_wdata_i;
                OSDSB_REG_VBLANK:    vblank_q    <= reg_wdata_i;
                OSDSB_REG_RANGE_CTL: range_ctl_q <= reg_wdata_i;
                default:             ;
            endcase
        end
    end

    // register reads, range control shows live range and calibration status
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else
        begin
            case (reg_addr_i)
                OSDSB_REG_LINE_LEN:  reg_rdata_o <= line_len_q;
                OSDSB_REG_HBLANK:    reg_rdata_o <= hblank_q;
                OSDSB_REG_VBLANK:    reg_rdata_o <= vblank_q;
                OSDSB_REG_RANGE_CTL: reg_rdata_o <= {cal_done_q,
                                                     range_ctl_q[OSDSB_AUTO_BIT:OSDSB_RANGE_MSB+1],
                                                     pll_range_o};
                default:             reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // flyback edges and presence
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hfb_d1_q <= 1'b0;
            vfb_d1_q <= 1'b0;
            h_seen_q <= 1'b0;
            v_seen_q <= 1'b0;
        end
        else
        begin
            hfb_d1_q <= hflyback_i;
            vfb_d1_q <= vflyback_i;
            if (h_rise)
                h_seen_q <= 1'b1;
            if (v_rise)
                v_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            osd_sync_o <= 1'b0;
        else
            osd_sync_o <= h_seen_q && v_seen_q;
    end

    // pixel counter, restarted on each horizontal flyback
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pix_cnt_q    <= '0;
            line_meas_q  <= '0;
            line_start_o <= 1'b0;
        end
        else
        begin
            line_start_o <= h_rise;
            if (h_rise)
            begin
                line_meas_q <= pix_cnt_q + PIX_W'(1);
                pix_cnt_q   <= '0;
            end
            else if (pix_cnt_q != '1)
                pix_cnt_q <= pix_cnt_q + PIX_W'(1);
        end
    end

    // horizontal blank: lead taken from previous line length, ends with flyback
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            hblank_o <= 1'b0;
        else if (!hblank_q[OSDSB_HB_EN_BIT])
            hblank_o <= 1'b0;
        else if (hflyback_i)
            hblank_o <= 1'b1;
        else if (lead_on && lead_pix != '0
                 && pix_cnt_q + PIX_W'(2) + lead_pix >= line_meas_q)
            hblank_o <= 1'b1;
        else
            hblank_o <= 1'b0;
    end

    // vertical blank for programmed line count
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            vb_cnt_q <= 7'h00;
        else if (!vblank_q[OSDSB_VB_EN_BIT])
            vb_cnt_q <= 7'h00;
        else if (v_rise)
            vb_cnt_q <= vb_lines;
        else if (h_rise && vb_cnt_q != 7'h00)
            vb_cnt_q <= vb_cnt_q - 7'h01;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            vblank_o <= 1'b0;
        else
            vblank_o <= vblank_q[OSDSB_VB_EN_BIT] && (v_rise || vb_cnt_q > 7'h01
                        || (vb_cnt_q == 7'h01 && !h_rise));
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            blank_o <= 1'b0;
        else
            blank_o <= hblank_o || vblank_o;
    end

    // range calibration sequence
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rf_q       <= OSDSB_RF_IDLE;
            cal_done_q <= 1'b0;
        end
        else if (cal_start && !(rf_q == OSDSB_RF_CAL && v_rise))
        begin
            // a repeated start restarts calibration from any state, except in CAL on a v_rise, which completes to READY
            rf_q       <= OSDSB_RF_CAL;
            cal_done_q <= 1'b0;
        end
        else
        begin
            case (rf_q)
                OSDSB_RF_IDLE:
                    rf_q <= OSDSB_RF_IDLE;
                OSDSB_RF_CAL:
                    if (v_rise)
                    begin
                        rf_q       <= OSDSB_RF_READY;
                        cal_done_q <= 1'b1;
                    end
                OSDSB_RF_READY:
                    if (range_ctl_q[OSDSB_AUTO_BIT])
                        rf_q <= OSDSB_RF_AUTO;
                OSDSB_RF_AUTO:
                    if (!range_ctl_q[OSDSB_AUTO_BIT])
                        rf_q <= OSDSB_RF_IDLE;
                default:
                    rf_q <= OSDSB_RF_IDLE;
            endcase
        end
    end

    osdsb_range_sel #(
        .PIX_W      (PIX_W)
    ) u_range_sel (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .line_end_i (h_rise),
        .line_cnt_i (line_meas_q),
        .target_i   (target_pix),
        .enable_i   (rf_q == OSDSB_RF_READY || rf_q == OSDSB_RF_AUTO),
        .range_o    (auto_range)
    );

    // pll outputs
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pix_per_line_o <= '0;
            pll_range_o    <= 2'h0;
            pll_auto_o     <= 1'b0;
        end
        else
        begin
            pix_per_line_o <= target_pix;
            pll_auto_o     <= rf_q == OSDSB_RF_AUTO;
            pll_range_o    <= (rf_q == OSDSB_RF_AUTO) ? auto_range
                              : range_ctl_q[OSDSB_RANGE_MSB:OSDSB_RANGE_LSB];
        end
    end
endmodule
